// [core/fcsd_ctrl.sv]
// Host-side command controller for a parallel NOR flash, Avalon-MM slave
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "fcsd_params.svh"
module fcsd_ctrl #(
   parameter int ADDR_W = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [15:0] flash_dq_o,
   input wire logic [15:0] flash_dq_i,
   output logic flash_dq_oe_n,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic flash_reset_n,
   input wire logic flash_rdy_busy
);
   import fcsd_pkg::*;

   localparam int RST_CYC = (`FCSD_RESET_PULSE_NS * `FCSD_CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC = (`FCSD_RDY_SETTLE_NS * `FCSD_CLK_MHZ + 999) / 1000;
   localparam int ERS_SUSP_CYC = `FCSD_ERS_SUSP_US * `FCSD_CLK_MHZ;
   localparam int PRG_SUSP_CYC = `FCSD_PRG_SUSP_US * `FCSD_CLK_MHZ;

   initial if (ADDR_W < 12 || ADDR_W > 24) $error("fcsd_ctrl: ADDR_W out of range");

   // --------------------------------------------------------------
   // Command step table
   // --------------------------------------------------------------
   function automatic logic [2:0] seq_len(fcsd_op_t op);
      unique case (op)
         FCSD_OP_POLL: seq_len = 3'd2;
         FCSD_OP_ID_ENTRY, FCSD_OP_ID_EXIT3: seq_len = 3'd3;
         FCSD_OP_PROG, FCSD_OP_PREG_PROG, FCSD_OP_LOCK_B, FCSD_OP_STATUS_B, FCSD_OP_SET_CFG: seq_len = 3'd4;
         FCSD_OP_CHIP_ERASE, FCSD_OP_SECT_ERASE, FCSD_OP_SPP_ENTER, FCSD_OP_LOCKDOWN: seq_len = 3'd6;
         default: seq_len = 3'd1;
      endcase
   endfunction

   // Returns {read, address, data}; upper data byte is zero on command cycles
   function automatic logic [ADDR_W+16:0] step_f(fcsd_op_t op, logic [2:0] idx, logic [ADDR_W-1:0] a,
                                                logic [15:0] d);
      logic [11:0] ca;
      logic [7:0] cd;
      logic rd;
      logic full;
      ca = 12'h555;
      cd = 8'hAA;
      rd = 1'b0;
      full = 1'b0;
      if (seq_len(op) == 3'd1 || seq_len(op) == 3'd2)
      begin
         unique case (op)
            FCSD_OP_SUSPEND: begin ca = 12'h000; cd = 8'hB0; end
            FCSD_OP_RESUME: begin ca = 12'h000; cd = 8'h30; end
            FCSD_OP_ID_EXIT1: begin ca = 12'h000; cd = 8'hF0; end
            FCSD_OP_CFI: begin ca = 12'h055; cd = 8'h98; end
            FCSD_OP_SPP_PROG: full = 1'b1;
            default: begin full = 1'b1; rd = 1'b1; end
         endcase
      end
      else if (idx == 3'd1 || idx == 3'd4)
      begin
         ca = 12'hAAA;
         cd = 8'h55;
      end
      else if (idx == 3'd2)
      begin
         unique case (op)
            FCSD_OP_PROG: cd = 8'hA0;
            FCSD_OP_PREG_PROG, FCSD_OP_LOCK_B: cd = 8'hC0;
            FCSD_OP_STATUS_B, FCSD_OP_ID_ENTRY: cd = 8'h90;
            FCSD_OP_SET_CFG: cd = 8'hD0;
            FCSD_OP_ID_EXIT3: cd = 8'hF0;
            default: cd = 8'h80;
         endcase
      end
      else if (idx == seq_len(op) - 3'd1)
      begin
         unique case (op)
            FCSD_OP_CHIP_ERASE: cd = 8'h10;
            FCSD_OP_SECT_ERASE: begin full = 1'b1; cd = 8'h30; end
            FCSD_OP_LOCKDOWN: begin full = 1'b1; cd = 8'h60; end
            FCSD_OP_SPP_ENTER: cd = 8'hA0;
            FCSD_OP_LOCK_B: begin ca = 12'h080; cd = 8'h00; end
            FCSD_OP_STATUS_B: begin ca = 12'h080; rd = 1'b1; end
            FCSD_OP_SET_CFG: begin ca = 12'h000; cd = {7'h00, d[0]}; end
            default: full = 1'b1;
         endcase
      end
      if (full)
         step_f = {rd, a, (op == FCSD_OP_SECT_ERASE || op == FCSD_OP_LOCKDOWN) ? {8'h00, cd} : d};
      else
         step_f = {rd, {(ADDR_W-12){1'b0}}, ca, 8'h00, cd};
   endfunction

   fcsd_state_t state_q;
   fcsd_op_t op_q;
   logic [2:0] idx_q;
   logic [ADDR_W-1:0] addr_q;
   logic [15:0] wdata_q;
   logic [15:0] rdata_q;
   logic [15:0] prev_q;
   logic [11:0] cnt_q;
   logic refused_q;
   logic id_mode_q;
   logic spp_q;
   logic cfg_q;
   logic last_erase_q;
   logic lock_q;
   logic rdy_s1_q;
   logic rdy_s2_q;
   logic bus_start;
   logic bus_done;
   logic [15:0] bus_rdata;
   logic [ADDR_W+16:0] step;
   logic rd_ack_q;
   logic ctrl_wr;
   logic busy;
   fcsd_op_t new_op;
   logic allowed;
   logic [31:0] status;

   assign step = step_f(op_q, idx_q, addr_q, wdata_q);
   assign bus_start = (state_q == FCSD_ISSUE);
   assign busy = (state_q != FCSD_IDLE);
   assign ctrl_wr = avs_write && avs_address == `FCSD_REG_CTRL;
   assign avs_waitrequest = (avs_read && !rd_ack_q) || (ctrl_wr && busy);

   // Single-pulse mode turns a program into one write; erase there would program data
   assign new_op = (spp_q && fcsd_op_t'(avs_writedata[4:0]) == FCSD_OP_PROG) ? FCSD_OP_SPP_PROG
                   : fcsd_op_t'(avs_writedata[4:0]);
   always_comb
   begin
      allowed = 1'b1;
      if (new_op == FCSD_OP_RESET || new_op == FCSD_OP_READ || new_op == FCSD_OP_POLL)
         allowed = 1'b1;
      else if (id_mode_q)
         allowed = new_op == FCSD_OP_ID_EXIT1 || new_op == FCSD_OP_ID_EXIT3
                   || new_op == FCSD_OP_CFI;
      else if (spp_q)
         allowed = new_op == FCSD_OP_SPP_PROG;
      else if (new_op == FCSD_OP_SPP_PROG || new_op > FCSD_OP_SPP_PROG)
         allowed = 1'b0;
   end

   // --------------------------------------------------------------
   // Ready/busy synchroniser
   // --------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdy_s1_q <= 1'b1;
         rdy_s2_q <= 1'b1;
      end
      else
      begin
         rdy_s1_q <= flash_rdy_busy;
         rdy_s2_q <= rdy_s1_q;
      end
   end

   // --------------------------------------------------------------
   // Avalon register file
   // --------------------------------------------------------------
   assign status = {20'h00000,
                    cfg_q ? ~rdata_q[7] : (rdata_q[7] != wdata_q[7]),
                    lock_q, rdata_q[5], rdata_q[7],
                    rdata_q[2] ^ prev_q[2], rdata_q[6] ^ prev_q[6],
                    cfg_q, spp_q, id_mode_q, refused_q, rdy_s2_q, busy};

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rd_ack_q <= 1'b0;
         avs_readdata <= 32'h00000000;
      end
      else
      begin
         rd_ack_q <= avs_read && !rd_ack_q;
         if (avs_read && !rd_ack_q)
         begin
            unique case (avs_address)
               `FCSD_REG_ADDR: avs_readdata <= 32'(addr_q);
               `FCSD_REG_WDATA: avs_readdata <= {16'h0000, wdata_q};
               `FCSD_REG_STATUS: avs_readdata <= status;
               `FCSD_REG_RDATA: avs_readdata <= {16'h0000, rdata_q};
               default: avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         addr_q <= '0;
         wdata_q <= 16'h0000;
      end
      else if (avs_write && !busy)
      begin
         if (avs_address == `FCSD_REG_ADDR)
            addr_q <= avs_writedata[ADDR_W-1:0];
         if (avs_address == `FCSD_REG_WDATA)
            wdata_q <= avs_writedata[15:0];
      end
   end

   // --------------------------------------------------------------
   // Command sequencer
   // --------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= FCSD_IDLE;
         op_q <= FCSD_OP_READ;
         idx_q <= 3'd0;
         cnt_q <= 12'h000;
         refused_q <= 1'b0;
         flash_reset_n <= 1'b1;
      end
      else
      begin
         unique case (state_q)
            FCSD_IDLE:
            begin
               if (ctrl_wr)
               begin
                  refused_q <= !allowed;
                  op_q <= new_op;
                  idx_q <= 3'd0;
                  if (allowed && new_op == FCSD_OP_RESET)
                  begin
                     flash_reset_n <= 1'b0;
                     cnt_q <= 12'(RST_CYC);
                     state_q <= FCSD_RESET_PULSE;
                  end
                  else if (allowed)
                     state_q <= FCSD_ISSUE;
               end
            end
            FCSD_ISSUE: state_q <= FCSD_WAIT_CYC;
            FCSD_WAIT_CYC:
            begin
               if (bus_done)
               begin
                  idx_q <= idx_q + 3'd1;
                  if (idx_q != seq_len(op_q) - 3'd1)
                     state_q <= FCSD_ISSUE;
                  else if (op_q == FCSD_OP_SUSPEND)
                  begin
                     cnt_q <= last_erase_q ? 12'(ERS_SUSP_CYC) : 12'(PRG_SUSP_CYC);
                     state_q <= FCSD_SUSP_WAIT;
                  end
                  else if (op_q inside {FCSD_OP_PROG, FCSD_OP_SPP_PROG, FCSD_OP_PREG_PROG, FCSD_OP_LOCK_B,
                                        FCSD_OP_CHIP_ERASE, FCSD_OP_SECT_ERASE})
                  begin
                     cnt_q <= 12'(SETTLE_CYC);
                     state_q <= FCSD_RDY_WAIT;
                  end
                  else
                     state_q <= FCSD_IDLE;
               end
            end
            FCSD_RDY_WAIT:
            begin
               if (cnt_q != 12'h000)
                  cnt_q <= cnt_q - 12'h001;
               else if (rdy_s2_q)
                  state_q <= FCSD_IDLE;
            end
            FCSD_SUSP_WAIT:
            begin
               if (cnt_q <= 12'h001)
                  state_q <= FCSD_IDLE;
               else
                  cnt_q <= cnt_q - 12'h001;
            end
            FCSD_RESET_PULSE:
            begin
               if (cnt_q <= 12'h001)
               begin
                  flash_reset_n <= 1'b1;
                  state_q <= FCSD_IDLE;
               end
               else
                  cnt_q <= cnt_q - 12'h001;
            end
            default: state_q <= FCSD_IDLE;
         endcase
      end
   end

   // --------------------------------------------------------------
   // Mirror of device modes and captured read data
   // --------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         id_mode_q <= 1'b0;
         spp_q <= 1'b0;
         cfg_q <= `FCSD_CFG_RESET;
         last_erase_q <= 1'b0;
         lock_q <= 1'b0;
         rdata_q <= 16'h0000;
         prev_q <= 16'h0000;
      end
      else if (state_q == FCSD_RESET_PULSE)
      begin
         id_mode_q <= 1'b0;
         spp_q <= 1'b0;
         cfg_q <= `FCSD_CFG_RESET;
      end
      else if (state_q == FCSD_WAIT_CYC && bus_done)
      begin
         if (step[ADDR_W+16])
         begin
            prev_q <= rdata_q;
            rdata_q <= bus_rdata;
         end
         if (op_q == FCSD_OP_STATUS_B && idx_q == 3'd3)
            lock_q <= !bus_rdata[1];
         if (idx_q == seq_len(op_q) - 3'd1)
         begin
            unique case (op_q)
               FCSD_OP_ID_ENTRY, FCSD_OP_STATUS_B: id_mode_q <= 1'b1;
               FCSD_OP_ID_EXIT1, FCSD_OP_ID_EXIT3: id_mode_q <= 1'b0;
               FCSD_OP_SPP_ENTER: spp_q <= 1'b1;
               FCSD_OP_SET_CFG: cfg_q <= wdata_q[0];
               FCSD_OP_CHIP_ERASE, FCSD_OP_SECT_ERASE: last_erase_q <= 1'b1;
               FCSD_OP_PROG: last_erase_q <= 1'b0;
               default: ;
            endcase
         end
      end
   end

   // --------------------------------------------------------------
   // Flash bus cycle engine
   // --------------------------------------------------------------
   fcsd_bus_cycle #(
      .ADDR_W(ADDR_W)
   ) u_bus (
      .clk(clk),
      .rst(rst),
      .start(bus_start),
      .rd(step[ADDR_W+16]),
      .addr(step[ADDR_W+15:16]),
      .wdata(step[15:0]),
      .done(bus_done),
      .rdata(bus_rdata),
      .flash_addr(flash_addr),
      .flash_dq_o(flash_dq_o),
      .flash_dq_i(flash_dq_i),
      .flash_dq_oe_n(flash_dq_oe_n),
      .flash_ce_n(flash_ce_n),
      .flash_we_n(flash_we_n),
      .flash_oe_n(flash_oe_n)
   );
endmodule // fcsd_ctrl

// [core/fcsd_params.svh]
// Offsets, field positions, reset values and timing figures of the flash command controller
`ifndef FCSD_PARAMS_SVH
`define FCSD_PARAMS_SVH

`define FCSD_REG_CTRL 3'h0
`define FCSD_REG_ADDR 3'h1
`define FCSD_REG_WDATA 3'h2
`define FCSD_REG_STATUS 3'h3
`define FCSD_REG_RDATA 3'h4

`define FCSD_CTRL_OP_LSB 0
`define FCSD_ST_BUSY 0
`define FCSD_ST_RDY 1
`define FCSD_ST_REFUSED 2
`define FCSD_ST_ID_MODE 3
`define FCSD_ST_SPP_MODE 4
`define FCSD_ST_CFG 5
`define FCSD_ST_TOGGLE 6
`define FCSD_ST_SECT_TOGGLE 7
`define FCSD_ST_POLL 8
`define FCSD_ST_TIMEOUT 9
`define FCSD_ST_LOCK 10
`define FCSD_ST_POLL_BUSY 11

`define FCSD_CFG_RESET 1'b0
`define FCSD_CLK_MHZ 100
`define FCSD_SETUP_NS 10
`define FCSD_WE_PULSE_NS 50
`define FCSD_ACCESS_NS 90
`define FCSD_HOLD_NS 20
`define FCSD_RESET_PULSE_NS 500
`define FCSD_RDY_SETTLE_NS 200
`define FCSD_ERS_SUSP_US 15
`define FCSD_PRG_SUSP_US 20

`endif

// [core/fcsd_pkg.sv]
// Types shared by the flash command controller
package fcsd_pkg;
   typedef enum logic [4:0] {
      FCSD_OP_READ = 5'h00,
      FCSD_OP_POLL = 5'h01,
      FCSD_OP_PROG = 5'h02,
      FCSD_OP_CHIP_ERASE = 5'h03,
      FCSD_OP_SECT_ERASE = 5'h04,
      FCSD_OP_SPP_ENTER = 5'h05,
      FCSD_OP_LOCKDOWN = 5'h06,
      FCSD_OP_SUSPEND = 5'h07,
      FCSD_OP_RESUME = 5'h08,
      FCSD_OP_ID_ENTRY = 5'h09,
      FCSD_OP_ID_EXIT3 = 5'h0A,
      FCSD_OP_ID_EXIT1 = 5'h0B,
      FCSD_OP_PREG_PROG = 5'h0C,
      FCSD_OP_LOCK_B = 5'h0D,
      FCSD_OP_STATUS_B = 5'h0E,
      FCSD_OP_SET_CFG = 5'h0F,
      FCSD_OP_CFI = 5'h10,
      FCSD_OP_RESET = 5'h11,
      FCSD_OP_SPP_PROG = 5'h12
   } fcsd_op_t;

   typedef enum logic [2:0] {
      FCSD_IDLE = 3'b000,
      FCSD_ISSUE = 3'b001,
      FCSD_WAIT_CYC = 3'b010,
      FCSD_RDY_WAIT = 3'b011,
      FCSD_SUSP_WAIT = 3'b100,
      FCSD_RESET_PULSE = 3'b101
   } fcsd_state_t;

   typedef enum logic [1:0] {
      FCSD_BUS_IDLE = 2'b00,
      FCSD_BUS_SETUP = 2'b01,
      FCSD_BUS_PULSE = 2'b10,
      FCSD_BUS_HOLD = 2'b11
   } fcsd_bus_state_t;
endpackage

// [core/fcsd_bus_cycle.sv]
// One asynchronous flash bus cycle, write or read, timed from clk
`timescale 1ns/1ps
`include "fcsd_params.svh"
module fcsd_bus_cycle #(
   parameter int ADDR_W = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic rd,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [15:0] wdata,
   output logic done,
   output logic [15:0] rdata,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [15:0] flash_dq_o,
   input wire logic [15:0] flash_dq_i,
   output logic flash_dq_oe_n,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n
);
   import fcsd_pkg::*;

   localparam int SETUP_CYC = (`FCSD_SETUP_NS * `FCSD_CLK_MHZ + 999) / 1000;
   localparam int WE_CYC = (`FCSD_WE_PULSE_NS * `FCSD_CLK_MHZ + 999) / 1000;
   // Two extra cycles let the pin synchroniser catch up before capture
   localparam int RD_CYC = (`FCSD_ACCESS_NS * `FCSD_CLK_MHZ + 999) / 1000 + 2;
   localparam int HOLD_CYC = (`FCSD_HOLD_NS * `FCSD_CLK_MHZ + 999) / 1000;

   initial if (ADDR_W < 12 || ADDR_W > 24) $error("fcsd_bus_cycle: ADDR_W out of range");

   fcsd_bus_state_t state_q;
   logic [7:0] cnt_q;
   logic rd_q;
   logic [15:0] dq_s1_q;
   logic [15:0] dq_s2_q;

   // --------------------------------------------------------------
   // Pin synchroniser
   // --------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         dq_s1_q <= 16'h0000;
         dq_s2_q <= 16'h0000;
      end
      else
      begin
         dq_s1_q <= flash_dq_i;
         dq_s2_q <= dq_s1_q;
      end
   end

   // --------------------------------------------------------------
   // Cycle sequencing
   // --------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= FCSD_BUS_IDLE;
         cnt_q <= 8'h00;
         rd_q <= 1'b0;
         done <= 1'b0;
         rdata <= 16'h0000;
         flash_addr <= '0;
         flash_dq_o <= 16'h0000;
         flash_dq_oe_n <= 1'b1;
         flash_ce_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_oe_n <= 1'b1;
      end
      else
      begin
         done <= 1'b0;
         unique case (state_q)
            FCSD_BUS_IDLE:
            begin
               if (start)
               begin
                  rd_q <= rd;
                  flash_addr <= addr;
                  flash_dq_o <= wdata;
                  flash_dq_oe_n <= rd;
                  flash_ce_n <= 1'b0;
                  cnt_q <= 8'(SETUP_CYC);
                  state_q <= FCSD_BUS_SETUP;
               end
            end
            FCSD_BUS_SETUP:
            begin
               if (cnt_q <= 8'h01)
               begin
                  flash_we_n <= rd_q;
                  flash_oe_n <= ~rd_q;
                  cnt_q <= rd_q ? 8'(RD_CYC) : 8'(WE_CYC);
                  state_q <= FCSD_BUS_PULSE;
               end
               else
                  cnt_q <= cnt_q - 8'h01;
            end
            FCSD_BUS_PULSE:
            begin
               if (cnt_q <= 8'h01)
               begin
                  if (rd_q)
                     rdata <= dq_s2_q;
                  flash_we_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  cnt_q <= 8'(HOLD_CYC);
                  state_q <= FCSD_BUS_HOLD;
               end
               else
                  cnt_q <= cnt_q - 8'h01;
            end
            FCSD_BUS_HOLD:
            begin
               if (cnt_q <= 8'h01)
               begin
                  flash_ce_n <= 1'b1;
                  flash_dq_oe_n <= 1'b1;
                  done <= 1'b1;
                  state_q <= FCSD_BUS_IDLE;
               end
               else
                  cnt_q <= cnt_q - 8'h01;
            end
         endcase
      end
   end
endmodule // fcsd_bus_cycle

// [verif/fcsd_ctrl_asserts.sv]
// Port checker for the flash command controller
`timescale 1ns/1ps
module fcsd_ctrl_asserts #(
   parameter int ADDR_W = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_waitrequest,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic [15:0] flash_dq_o,
   input wire logic flash_dq_oe_n,
   input wire logic flash_ce_n,
   input wire logic flash_we_n,
   input wire logic flash_oe_n,
   input wire logic flash_reset_n
);
   // ----------------
   // Properties
   // ----------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_cmd_upper_zero: assert property (!flash_we_n && flash_addr[11:0] == 12'h555 |-> flash_dq_o[15:8] == 8'h00)
      else $error("command upper byte not zero");
   a_unlock_first: assert property (!flash_we_n && flash_dq_o[7:0] == 8'hAA |-> flash_addr[11:0] == 12'h555)
      else $error("first unlock address wrong");
   a_unlock_second: assert property (!flash_we_n && flash_dq_o[7:0] == 8'h55 |-> flash_addr[10:0] == 11'h2AA)
      else $error("second unlock address wrong");
   a_drive_on_write: assert property (!flash_we_n |-> !flash_dq_oe_n && !flash_ce_n && flash_oe_n)
      else $error("write strobe without driven bus");
   a_float_on_read: assert property (!flash_oe_n |-> flash_dq_oe_n && flash_we_n)
      else $error("bus driven during read");
   a_we_pulse: assert property ($fell(flash_we_n) |-> (!flash_we_n) [*5] ##1 flash_we_n)
      else $error("write pulse length wrong");
   a_rd_answer: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("register read answer late");
   a_reset_quiet: assert property (!flash_reset_n |-> flash_ce_n && flash_we_n)
      else $error("bus cycle during device reset");
   a_reset_width: assert property ($fell(flash_reset_n) |-> (!flash_reset_n) [*8])
      else $error("device reset pulse short");
   c_write: cover property ($fell(flash_we_n));
   c_read: cover property ($fell(flash_oe_n));
   c_reset: cover property ($fell(flash_reset_n));
endmodule // fcsd_ctrl_asserts

bind fcsd_ctrl fcsd_ctrl_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk, .rst, .avs_read, .avs_waitrequest,
   .flash_addr, .flash_dq_o, .flash_dq_oe_n, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n);

// [verif/fcsd_flash_model.sv]
// Behavioural flash device facing the controller
`timescale 1ns/1ps
module fcsd_flash_model (
   input wire logic clk,
   input wire logic [19:0] a,
   input wire logic [15:0] d,
   output logic [15:0] q,
   output logic q_en,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic reset_n,
   output logic rdy
);
   // ----------------
   // Device state
   // ----------------
   logic [15:0] mem [0:15];
   logic [255:0] lk = '0;
   logic [15:0] pd = '0;
   logic [2:0] st = '0;
   logic [7:0] m, c;
   logic id = 0, spp = 0, to = 0, tg = 0, lkb = 1;
   logic cfg = 0;
   int bc = 0, sv = 0;
   assign rdy = bc == 0;
   assign q_en = !ce_n && !oe_n;
   assign q = id && a[11:0] == 12'h080 ? {14'h0, lkb, 1'b1} : bc > 0 || to ?
      {8'h0, cfg ? 1'b0 : ~pd[7], tg, to, 5'h0} : mem[a[3:0]];
   always @(posedge oe_n) tg = ~tg;
   always @(posedge clk) if (bc > 0) bc = bc - 1;
   // Unlock bytes after the first are not checked; only an unknown command byte drops back to the first cycle
   always @(posedge we_n or negedge reset_n)
      if (!reset_n)
      begin
         {st, id, spp, to} = '0;
         lk = '0;
      end
      else if (!ce_n)
      begin
         c = d[7:0];
         to = 1'b0;
         if (spp) mem[a[3:0]] = d;
         else if (st == 0 && !(c == 8'hAA && a[11:0] == 12'h555))
         begin
            if (c == 8'hB0) {sv, bc} = {bc, 32'h0};
            else if (c == 8'h30) bc = sv;
            else if (c != 8'h98) id = 1'b0;
         end
         else if (st == 2)
         begin
            st = c == 8'h80 ? 3'd3 : c == 8'hA0 || c == 8'hC0 || c == 8'hD0 ? 3'd6 : 3'd0;
            m = c;
            if (c == 8'h90) id = 1'b1;
            if (c == 8'hF0) id = 1'b0;
         end
         else if (st == 5)
         begin
            st = 0;
            if (c == 8'h60) lk[a[19:12]] = 1'b1;
            if (c == 8'hA0) spp = 1'b1;
            if (c == 8'h10 || c == 8'h30) bc = lk[a[19:12]] ? 10 : 300;
            if (c == 8'h30) to = lk[a[19:12]];
         end
         else if (st == 6)
         begin
            st = 0;
            if (m == 8'hA0) {mem[a[3:0]], pd} = {d, d};
            if (m == 8'hA0) bc = 100;
            if (m == 8'hC0 && a[11:0] == 12'h080 && !d[1]) lkb = 1'b0;
            if (m == 8'hD0) cfg = d[0];
         end
         else st = st + 1;
      end
endmodule // fcsd_flash_model

// [verif/tb_flash_command_status_decoder.sv]
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
`include "fcsd_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_flash_command_status_decoder;
   import fcsd_pkg::*;
   // ----------------
   // Harness
   // ----------------
   logic clk = 0, rst = 1, r = 0, w = 0;
   logic [2:0] adr = '0;
   logic [31:0] wd = '0, rdd, s;
   logic [19:0] fa;
   logic [15:0] fdo, fq, dq, lastv = '0;
   logic wq, doe_n, ce_n, we_n, oe_n, rs_n, rdy, fq_en;
   int miscompares = 0, checks_done = 0;
   always #5 clk = ~clk;
   // Released bus shows a changing pattern, never the last value
   assign dq = !doe_n ? fdo : fq_en ? fq : ~lastv;
   always @(posedge clk) lastv <= dq;
   fcsd_ctrl #(.ADDR_W(20)) dut (.clk, .rst, .avs_address(adr), .avs_read(r), .avs_write(w),
      .avs_writedata(wd), .avs_readdata(rdd), .avs_waitrequest(wq), .flash_addr(fa), .flash_dq_o(fdo),
      .flash_dq_i(dq), .flash_dq_oe_n(doe_n), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
      .flash_reset_n(rs_n), .flash_rdy_busy(rdy));
   fcsd_flash_model fm (.clk, .a(fa), .d(dq), .q(fq), .q_en(fq_en), .ce_n, .we_n, .oe_n, .reset_n(rs_n), .rdy);
   task automatic wr(input logic [2:0] a, input logic [31:0] v);
      adr <= a;
      wd <= v;
      w <= 1'b1;
      @(posedge clk);
      while (wq) @(posedge clk);
      w <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [2:0] a, output logic [31:0] v);
      adr <= a;
      r <= 1'b1;
      @(posedge clk);
      while (wq) @(posedge clk);
      v = rdd;
      r <= 1'b0;
      @(posedge clk);
   endtask
   task automatic op(input fcsd_op_t o, input logic [31:0] ad, input logic [31:0] dt);
      int n;
      wr(`FCSD_REG_ADDR, ad);
      wr(`FCSD_REG_WDATA, dt);
      wr(`FCSD_REG_CTRL, {27'h0, o});
      n = 0;
      s = 32'h1;
      while (s[`FCSD_ST_BUSY] !== 1'b0 && n < 9000)
      begin
         rd(`FCSD_REG_STATUS, s);
         n++;
      end
      `CHK(n < 9000, 1'b1)
   endtask
   task automatic t_basic;
      rd(`FCSD_REG_STATUS, s);
      `CHK(s[`FCSD_ST_CFG], 1'b0)
      rd(3'h7, s);
      `CHK(s, 32'h0)
      op(FCSD_OP_PROG, 32'h12345, 32'hA55A);
      `CHK(fm.mem[5], 16'hA55A)
      op(FCSD_OP_READ, 32'h12345, 32'h0);
      rd(`FCSD_REG_RDATA, s);
      `CHK(s[15:0], 16'hA55A)
      $display("t_basic done");
   endtask
   task automatic t_blockb;
      op(FCSD_OP_STATUS_B, 0, 0);
      `CHK(s[`FCSD_ST_LOCK], 1'b0)
      op(FCSD_OP_PROG, 32'h1, 32'h1);
      `CHK(s[`FCSD_ST_REFUSED], 1'b1)
      op(FCSD_OP_ID_EXIT1, 0, 0);
      `CHK(s[`FCSD_ST_ID_MODE], 1'b0)
      op(FCSD_OP_LOCK_B, 0, 0);
      `CHK(fm.lkb, 1'b0)
      op(FCSD_OP_STATUS_B, 0, 0);
      `CHK(s[`FCSD_ST_LOCK], 1'b1)
      op(FCSD_OP_ID_EXIT3, 0, 0);
      `CHK(fm.id, 1'b0)
      op(FCSD_OP_ID_ENTRY, 0, 0);
      `CHK(s[`FCSD_ST_ID_MODE], 1'b1)
      op(FCSD_OP_CFI, 0, 0);
      `CHK(s[`FCSD_ST_REFUSED], 1'b0)
      op(FCSD_OP_ID_EXIT1, 0, 0);
      `CHK(fm.id, 1'b0)
      $display("t_blockb done");
   endtask
   task automatic t_lock;
      op(FCSD_OP_LOCKDOWN, 32'h0A000, 0);
      op(FCSD_OP_SECT_ERASE, 32'h0AFFF, 0);
      op(FCSD_OP_POLL, 32'h0A123, 0);
      `CHK(s[`FCSD_ST_TIMEOUT], 1'b1)
      `CHK(s[`FCSD_ST_POLL_BUSY], 1'b1)
      op(FCSD_OP_RESET, 0, 0);
      op(FCSD_OP_SECT_ERASE, 32'h0A800, 0);
      `CHK(fm.to, 1'b0)
      $display("t_lock done");
   endtask
   task automatic t_spp;
      time t0;
      op(FCSD_OP_SET_CFG, 0, 1);
      `CHK(fm.cfg, 1'b1)
      op(FCSD_OP_SPP_ENTER, 0, 0);
      `CHK(s[`FCSD_ST_SPP_MODE], 1'b1)
      op(FCSD_OP_PROG, 32'h3, 32'h1234);
      `CHK(fm.mem[3], 16'h1234)
      op(FCSD_OP_CHIP_ERASE, 0, 0);
      `CHK(s[`FCSD_ST_REFUSED], 1'b1)
      op(FCSD_OP_RESET, 0, 0);
      `CHK(fm.spp, 1'b0)
      // The single-pulse program leaves last_erase_q set by the sector erase, so the erase suspend wait applies
      t0 = $time;
      op(FCSD_OP_SUSPEND, 0, 0);
      `CHK(($time - t0 >= `FCSD_ERS_SUSP_US * 1000) && ($time - t0 < `FCSD_PRG_SUSP_US * 1000), 1'b1)
      op(FCSD_OP_RESUME, 0, 0);
      `CHK(s[`FCSD_ST_REFUSED], 1'b0)
      $display("t_spp done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_basic;
      t_blockb;
      t_lock;
      t_spp;
      results;
   end
   // Roughly thirty times the expected run
   initial
   begin
      #900000;
      miscompares++;
      results;
   end
endmodule // tb_flash_command_status_decoder
